//--- dsd_regs.svh
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH

`define DSD_ADDR_W 12
`define DSD_OFF_CTRL 12'h000
`define DSD_OFF_STAT 12'h004
`define DSD_OFF_RDCODE 12'h008
`define DSD_OFF_WRCODE 12'h00C
`define DSD_OFF_LVCODE 12'h010

`define DSD_CTRL_DDR_BIT 0
`define DSD_STAT_RDP_LSB 0
`define DSD_STAT_WRP_LSB 4
`define DSD_STAT_ST_LSB 8
`define DSD_STAT_BURST_BIT 16
`define DSD_STAT_RDLIM_BIT 17
`define DSD_STAT_WRLIM_BIT 18
`define DSD_STAT_LVLIM_BIT 19

`define DSD_CODE_W 9
`define DSD_CODE_RST 9'h000
`define DSD_CODE_MAX 9'h1FF
`define DSD_PTR_W 3
`define DSD_PTR_RST 3'h0
`define DSD_GROUP_PINS 16
`define DSD_DIV_RST 2'h0

`endif

//--- dsd_pkg.sv
`include "dsd_regs.svh"

package dsd_pkg;

   typedef logic [`DSD_CODE_W-1:0] dsd_code_t;
   typedef logic [`DSD_PTR_W-1:0] dsd_ptr_t;

   // margin / leveling adjust controls from core logic
   typedef struct packed {
      logic load_n;
      logic step;
      logic dir;
   } dsd_margin_s;

   typedef enum logic [1:0] {
      DSD_RD_IDLE = 2'b00,
      DSD_RD_WAIT = 2'b01,
      DSD_RD_WIN = 2'b10
   } dsd_rd_e;

   function automatic dsd_ptr_t dsd_bin2gray(input dsd_ptr_t b);
      return b ^ (b >> 1);
   endfunction

   function automatic dsd_ptr_t dsd_gray2bin(input dsd_ptr_t g);
      dsd_ptr_t b;
      b[`DSD_PTR_W-1] = g[`DSD_PTR_W-1];
      for (int i = `DSD_PTR_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

//--- dsd_delay_line.sv
`timescale 1ns/1ps
`include "dsd_regs.svh"

module dsd_delay_line
   import dsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire dsd_margin_s margin_i,
   input wire dsd_code_t code_init_i,
   output dsd_code_t code_o,
   output logic limit_o
);

   typedef struct packed {
      dsd_code_t code;
      logic step_q;
      logic limit;
   } dsd_dl_s;

   dsd_dl_s st_r;
   dsd_dl_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.step_q = margin_i.step;
      if (!margin_i.load_n)
      begin
         st_nxt.code = code_init_i;
         st_nxt.limit = 1'b0;
      end
      // one tap per rising edge of step, so a held step moves only once
      else if (margin_i.step && !st_r.step_q)
      begin
         if (!margin_i.dir)
         begin
            if (st_r.code == `DSD_CODE_MAX)
               st_nxt.limit = 1'b1;
            else
               st_nxt.code = st_r.code + 1'b1;
         end
         else
         begin
            if (st_r.code == `DSD_CODE_RST)
               st_nxt.limit = 1'b1;
            else
               st_nxt.code = st_r.code - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_r <= '{code: `DSD_CODE_RST, step_q: 1'b0, limit: 1'b0};
      else
         st_r <= st_nxt;
   end

   assign code_o = st_r.code;
   assign limit_o = st_r.limit;

endmodule // dsd_delay_line

//--- dsd_tristate.sv
`timescale 1ns/1ps

module dsd_tristate
   import dsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ddr_mode_i,
   input wire logic td_i,
   input wire logic [1:0] td_pair_i,
   output logic tq_o
);

   typedef struct packed {
      logic [1:0] pair;
      logic phase;
      logic tq;
   } dsd_ts_s;

   dsd_ts_s st_r;
   dsd_ts_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.phase = ddr_mode_i ? ~st_r.phase : 1'b0;
      if (ddr_mode_i)
      begin
         // pair taken at slow rate, bits sent one per fast cycle
         if (!st_r.phase)
            st_nxt.pair = td_pair_i;
         st_nxt.tq = st_r.phase ? st_r.pair[1] : st_r.pair[0];
      end
      else
         st_nxt.tq = td_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tq_o = st_r.tq;

endmodule // dsd_tristate

//--- dsd_strobe_top.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dsd_regs.svh"

module dsd_strobe_top
   import dsd_pkg::*;
#(
   parameter int GROUP_PINS = `DSD_GROUP_PINS
)
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic strobe_clk_i,
   input wire logic [`DSD_ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic tristate_ctrl_in_i,
   input wire logic [1:0] tristate_pair_in_i,
   output logic tristate_ctrl_out_o,
   input wire logic [1:0] read_ind_i,
   input wire logic [2:0] read_pulse_select_i,
   input wire dsd_margin_s rd_margin_i,
   input wire dsd_margin_s wr_margin_i,
   input wire dsd_margin_s level_margin_i,
   input wire dsd_code_t delay_code_in_i,
   output dsd_code_t delay_code_out_o,
   output dsd_code_t write_delay_code_o,
   output dsd_code_t level_delay_code_o,
   output logic read_count_out_o,
   output logic write_count_out_o,
   output logic write_strobe_clock_o,
   output logic write_data_clock_o,
   output dsd_ptr_t [GROUP_PINS-1:0] fifo_read_pointer_o,
   output dsd_ptr_t [GROUP_PINS-1:0] fifo_write_pointer_o,
   output logic read_valid_start_o,
   output logic burst_detect_flag_o
);

   if (GROUP_PINS != `DSD_GROUP_PINS)
      $error("strobe group must hold sixteen cells");

   // reset release, one synchroniser per domain
   logic [1:0] rst_ref_q;
   logic [1:0] rst_lnk_q;
   logic rst_n;
   logic rst_lnk_n;

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_ref_q <= 2'b00;
      else
         rst_ref_q <= {rst_ref_q[0], 1'b1};
   end

   always_ff @(posedge strobe_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_lnk_q <= 2'b00;
      else
         rst_lnk_q <= {rst_lnk_q[0], 1'b1};
   end

   assign rst_n = rst_ref_q[1];
   assign rst_lnk_n = rst_lnk_q[1];

   // strobe-domain state: fifo write side
   typedef struct packed {
      logic win_s1;
      logic win_s2;
      dsd_ptr_t wr_ptr;
      dsd_ptr_t wr_gray;
   } dsd_lnk_s;

   // reference-domain state: fifo read side, read window, bus, write clocks
   typedef struct packed {
      logic ddr_mode;
      logic burst_sticky;
      dsd_rd_e rd_st;
      logic [2:0] wait_cnt;
      dsd_ptr_t rd_ptr;
      dsd_ptr_t wg_s1;
      dsd_ptr_t wg_s2;
      logic seen;
      logic valid_pls;
      logic burst_pls;
      logic [1:0] wdiv;
      logic wclk;
      logic dclk;
      logic [31:0] prdata;
      logic pslverr;
   } dsd_ref_s;

   dsd_lnk_s lnk_r;
   dsd_lnk_s lnk_nxt;
   dsd_ref_s ref_r;
   dsd_ref_s ref_nxt;

   dsd_code_t rd_code;
   logic rd_lim;
   logic wr_lim;
   logic lv_lim;
   dsd_ptr_t wr_ptr_sync;
   logic fifo_has_data;
   logic win_open;
   logic setup_ph;
   logic access_ph;
   logic addr_ok;

   // strobe-domain write pointer; clock may stop between bursts,
   // so nothing here waits for an edge after the last strobe
   always_comb
   begin
      lnk_nxt = lnk_r;
      lnk_nxt.win_s1 = win_open;
      lnk_nxt.win_s2 = lnk_r.win_s1;
      if (lnk_r.win_s2)
      begin
         lnk_nxt.wr_ptr = lnk_r.wr_ptr + 1'b1;
         lnk_nxt.wr_gray = dsd_bin2gray(lnk_nxt.wr_ptr);
      end
   end

   always_ff @(posedge strobe_clk_i or negedge rst_lnk_n)
   begin
      if (!rst_lnk_n)
         lnk_r <= '{win_s1: 1'b0, win_s2: 1'b0, wr_ptr: `DSD_PTR_RST,
                    wr_gray: `DSD_PTR_RST};
      else
         lnk_r <= lnk_nxt;
   end

   assign win_open = (ref_r.rd_st == DSD_RD_WIN);
   assign wr_ptr_sync = dsd_gray2bin(ref_r.wg_s2);
   assign fifo_has_data = (wr_ptr_sync != ref_r.rd_ptr);
   assign setup_ph = psel_i && !penable_i;
   assign access_ph = psel_i && penable_i;

   always_comb
   begin
      case (paddr_i)
         `DSD_OFF_CTRL, `DSD_OFF_STAT, `DSD_OFF_RDCODE,
         `DSD_OFF_WRCODE, `DSD_OFF_LVCODE: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      ref_nxt = ref_r;
      ref_nxt.valid_pls = 1'b0;
      ref_nxt.burst_pls = 1'b0;
      ref_nxt.wg_s1 = lnk_r.wr_gray;
      ref_nxt.wg_s2 = ref_r.wg_s1;

      // fifo read side on the edge clock
      if (fifo_has_data)
      begin
         ref_nxt.rd_ptr = ref_r.rd_ptr + 1'b1;
         if (win_open && !ref_r.seen)
            ref_nxt.valid_pls = 1'b1;
         if (win_open)
            ref_nxt.seen = 1'b1;
      end

      // read window: opens after the selected number of cycles
      case (ref_r.rd_st)
         DSD_RD_IDLE:
         begin
            ref_nxt.seen = 1'b0;
            if (read_ind_i != 2'b00)
            begin
               ref_nxt.wait_cnt = read_pulse_select_i;
               ref_nxt.rd_st = (read_pulse_select_i == 3'h0) ? DSD_RD_WIN : DSD_RD_WAIT;
            end
         end
         DSD_RD_WAIT:
         begin
            ref_nxt.wait_cnt = ref_r.wait_cnt - 1'b1;
            if (ref_r.wait_cnt == 3'h1)
               ref_nxt.rd_st = DSD_RD_WIN;
         end
         DSD_RD_WIN:
         begin
            // close only once the controller is done and the fifo drained
            if (read_ind_i == 2'b00 && !fifo_has_data)
            begin
               ref_nxt.rd_st = DSD_RD_IDLE;
               ref_nxt.burst_pls = ref_r.seen;
            end
         end
         default: ref_nxt.rd_st = DSD_RD_IDLE;
      endcase

      // write clocks: quarter-period phases of a four-cycle divider
      ref_nxt.wdiv = ref_r.wdiv + 1'b1;
      ref_nxt.wclk = ref_nxt.wdiv[1];
      ref_nxt.dclk = ref_nxt.wdiv[1] ^ ref_nxt.wdiv[0];

      // apb: read data and error registered at setup, no wait states
      if (setup_ph)
      begin
         ref_nxt.pslverr = !addr_ok;
         ref_nxt.prdata = '0;
         case (paddr_i)
            `DSD_OFF_CTRL: ref_nxt.prdata[`DSD_CTRL_DDR_BIT] = ref_r.ddr_mode;
            `DSD_OFF_STAT:
            begin
               ref_nxt.prdata[`DSD_STAT_RDP_LSB +: `DSD_PTR_W] = ref_r.rd_ptr;
               ref_nxt.prdata[`DSD_STAT_WRP_LSB +: `DSD_PTR_W] = wr_ptr_sync;
               ref_nxt.prdata[`DSD_STAT_ST_LSB +: 2] = ref_r.rd_st;
               ref_nxt.prdata[`DSD_STAT_BURST_BIT] = ref_r.burst_sticky;
               ref_nxt.prdata[`DSD_STAT_RDLIM_BIT] = rd_lim;
               ref_nxt.prdata[`DSD_STAT_WRLIM_BIT] = wr_lim;
               ref_nxt.prdata[`DSD_STAT_LVLIM_BIT] = lv_lim;
            end
            `DSD_OFF_RDCODE: ref_nxt.prdata[`DSD_CODE_W-1:0] = rd_code;
            `DSD_OFF_WRCODE: ref_nxt.prdata[`DSD_CODE_W-1:0] = write_delay_code_o;
            `DSD_OFF_LVCODE: ref_nxt.prdata[`DSD_CODE_W-1:0] = level_delay_code_o;
            default: ref_nxt.prdata = '0;
         endcase
      end

      if (access_ph && pwrite_i && addr_ok)
      begin
         if (paddr_i == `DSD_OFF_CTRL && pstrb_i[0])
            ref_nxt.ddr_mode = pwdata_i[`DSD_CTRL_DDR_BIT];
         if (paddr_i == `DSD_OFF_STAT && pstrb_i[2] && pwdata_i[`DSD_STAT_BURST_BIT])
            ref_nxt.burst_sticky = 1'b0;
      end
      // a new burst in the clearing cycle still shows
      if (ref_nxt.burst_pls)
         ref_nxt.burst_sticky = 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         ref_r <= '{ddr_mode: 1'b0, burst_sticky: 1'b0, rd_st: DSD_RD_IDLE,
                    wait_cnt: 3'h0, rd_ptr: `DSD_PTR_RST, wg_s1: `DSD_PTR_RST,
                    wg_s2: `DSD_PTR_RST, seen: 1'b0, valid_pls: 1'b0,
                    burst_pls: 1'b0, wdiv: `DSD_DIV_RST, wclk: 1'b0, dclk: 1'b0,
                    prdata: 32'h0000_0000, pslverr: 1'b0};
      else
         ref_r <= ref_nxt;
   end

   // read delay code steers the analog slave cell on the incoming strobe
   dsd_delay_line u_rd_line (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .margin_i(rd_margin_i),
      .code_init_i(delay_code_in_i),
      .code_o(rd_code),
      .limit_o(rd_lim)
   );

   dsd_delay_line u_wr_line (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .margin_i(wr_margin_i),
      .code_init_i(delay_code_in_i),
      .code_o(write_delay_code_o),
      .limit_o(wr_lim)
   );

   dsd_delay_line u_lv_line (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .margin_i(level_margin_i),
      .code_init_i(delay_code_in_i),
      .code_o(level_delay_code_o),
      .limit_o(lv_lim)
   );

   dsd_tristate u_tristate (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .ddr_mode_i(ref_r.ddr_mode),
      .td_i(tristate_ctrl_in_i),
      .td_pair_i(tristate_pair_in_i),
      .tq_o(tristate_ctrl_out_o)
   );

   always_comb
   begin
      for (int i = 0; i < GROUP_PINS; i++)
      begin
         fifo_read_pointer_o[i] = ref_r.rd_ptr;
         fifo_write_pointer_o[i] = lnk_r.wr_ptr;
      end
   end

   assign delay_code_out_o = rd_code;
   assign read_count_out_o = rd_lim;
   assign write_count_out_o = wr_lim;
   assign write_strobe_clock_o = ref_r.wclk;
   assign write_data_clock_o = ref_r.dclk;
   assign read_valid_start_o = ref_r.valid_pls;
   assign burst_detect_flag_o = ref_r.burst_pls;
   assign prdata_o = ref_r.prdata;
   assign pslverr_o = ref_r.pslverr && access_ph;
   assign pready_o = 1'b1;

endmodule // dsd_strobe_top

//--- dsd_strobe_top_monitor.sv
`timescale 1ns/1ps
`include "dsd_regs.svh"

module dsd_strobe_monitor
   import dsd_pkg::*;
#(
   parameter int GROUP_PINS = 16
)
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [`DSD_ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic tristate_ctrl_in_i,
   input wire logic [1:0] tristate_pair_in_i,
   input wire logic tristate_ctrl_out_o,
   input wire dsd_margin_s rd_margin_i,
   input wire dsd_margin_s wr_margin_i,
   input wire dsd_margin_s level_margin_i,
   input wire dsd_code_t delay_code_in_i,
   input wire dsd_code_t delay_code_out_o,
   input wire dsd_code_t write_delay_code_o,
   input wire dsd_code_t level_delay_code_o,
   input wire logic write_strobe_clock_o,
   input wire logic write_data_clock_o,
   input wire dsd_ptr_t [GROUP_PINS-1:0] fifo_read_pointer_o,
   input wire logic read_valid_start_o
);
   logic [2:0] up_r;
   logic ddr_r;
   dsd_ptr_t rp;

   assign rp = fifo_read_pointer_o[0];

   // internal reset trails the pin by two flops, so wait before judging
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         up_r <= 3'h0;
         ddr_r <= 1'b0;
      end
      else
      begin
         if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
         if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000 && pstrb_i[0])
            ddr_r <= pwdata_i[0];
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i || up_r != 3'h7);

   a_sdr_one_flop: assert property ($past(!ddr_r) |->
      tristate_ctrl_out_o == $past(tristate_ctrl_in_i)) else $error("single rate path");
   a_ddr_bit_order: assert property ($past(ddr_r) && $past(ddr_r, 2) && $past(ddr_r, 3) |->
      tristate_ctrl_out_o == $past(tristate_pair_in_i[0], 3) ||
      tristate_ctrl_out_o == $past(tristate_pair_in_i[1], 2)) else $error("double rate order");
   a_ptr_all_cells: assert property (fifo_read_pointer_o == {GROUP_PINS{rp}})
      else $error("pointer differs between cells");
   a_ptr_wrap_step: assert property (rp == $past(rp) || rp == $past(rp) + 3'h1)
      else $error("read pointer jump");
   a_rd_step_up: assert property (rd_margin_i.load_n && rd_margin_i.step &&
      !$past(rd_margin_i.step) && !rd_margin_i.dir && delay_code_out_o != 9'h1FF
      |=> delay_code_out_o == $past(delay_code_out_o) + 9'h1) else $error("read step up");
   a_wr_step_down: assert property (wr_margin_i.load_n && wr_margin_i.step &&
      !$past(wr_margin_i.step) && wr_margin_i.dir && write_delay_code_o != 9'h000
      |=> write_delay_code_o == $past(write_delay_code_o) - 9'h1) else $error("write step down");
   a_step_held: assert property (rd_margin_i.load_n && rd_margin_i.step &&
      $past(rd_margin_i.step) |=> $stable(delay_code_out_o)) else $error("held step moved");
   a_lvl_load: assert property (!level_margin_i.load_n |=>
      level_delay_code_o == $past(delay_code_in_i)) else $error("leveling load");
   a_wclk_quarter: assert property (write_strobe_clock_o == $past(write_data_clock_o))
      else $error("write clock offset");
   a_valid_pulse: assert property (read_valid_start_o |=> !read_valid_start_o)
      else $error("valid pulse length");
   a_valid_cause: assert property (read_valid_start_o |-> rp != $past(rp, 2))
      else $error("valid without read");

   c_ddr_mode: cover property (ddr_r && tristate_ctrl_out_o);
   c_valid: cover property (read_valid_start_o);
   c_limit: cover property (rd_margin_i.step && delay_code_out_o == 9'h1FF);
endmodule // dsd_strobe_monitor

//--- dsd_mem_model.sv
`timescale 1ns/1ps

module dsd_mem_model
#(
   parameter int LANE_PINS = 16
)
(
   input wire logic go_i,
   input wire logic [3:0] edges_i,
   output logic strobe_o
);
   // strobe parks low between bursts, already shifted by the delay cell
   initial strobe_o = 1'b0;

   // strobe pair on the group's two fixed pins, data and mask on the rest;
   // no supply-assist pins driven, noise relief is not modelled here
   if (LANE_PINS < 11)
      $error("group too narrow for a data lane");

   always @(posedge go_i)
   begin
      #3.3;
      repeat (edges_i)
      begin
         strobe_o = 1'b1;
         #7.5;
         strobe_o = 1'b0;
         #7.5;
      end
   end
endmodule // dsd_mem_model

//--- tb_ddr_strobe_and_tristate_io.sv
`timescale 1ns/1ps
`include "dsd_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module tb_ddr_strobe_and_tristate_io;
   import dsd_pkg::*;
   logic ref_clk_i = 0, resetn_i, strobe_clk_i, go = 0;
   logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o;
   logic [3:0] pstrb_i = 4'hF, n_edges = 0;
   logic tristate_ctrl_in_i = 0, tristate_ctrl_out_o, t, read_count_out_o, write_count_out_o;
   logic [1:0] tristate_pair_in_i = 0, read_ind_i = 0;
   logic [2:0] read_pulse_select_i = 0;
   dsd_margin_s rd_margin_i = 3'h4, wr_margin_i = 3'h4, level_margin_i = 3'h4;
   dsd_code_t delay_code_in_i = 0, delay_code_out_o, write_delay_code_o, level_delay_code_o, v;
   logic write_strobe_clock_o, write_data_clock_o, read_valid_start_o, burst_detect_flag_o;
   dsd_ptr_t [15:0] fifo_read_pointer_o, fifo_write_pointer_o;
   int n_mismatch = 0, checks = 0, seed = 32'hc2a4, n_valid = 0, cyc = 0, w;
   logic [32:0] apb_q[$], e_v;
   int tq_c[$];
   logic tq_v[$], te;

   always #25 ref_clk_i = ~ref_clk_i;

   dsd_strobe_top #(.GROUP_PINS(16)) dut (.*);
   dsd_mem_model mem (.go_i(go), .edges_i(n_edges), .strobe_o(strobe_clk_i));

   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (read_valid_start_o === 1'b1)
         n_valid++;
      if (tq_c.size() > 0 && tq_c[0] == cyc)
      begin
         void'(tq_c.pop_front());
         te = tq_v.pop_front();
         `CHK(tristate_ctrl_out_o, te)
      end
      if (psel_i && penable_i && pready_o && !pwrite_i && apb_q.size() > 0)
      begin
         e_v = apb_q.pop_front();
         `CHK({pslverr_o, prdata_o}, e_v)
      end
   end

   task end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [32:0] e);
      @(posedge ref_clk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      if (!wr)
         apb_q.push_back(e);
      @(posedge ref_clk_i);
      penable_i <= 1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      psel_i <= 0;
      penable_i <= 0;
   endtask

   task mg(input int i, input logic [2:0] m);
      @(posedge ref_clk_i);
      if (i == 0)
         rd_margin_i <= m;
      else if (i == 1)
         wr_margin_i <= m;
      else
         level_margin_i <= m;
   endtask

   initial
   begin
      #2_000_000;
      n_mismatch++;
      end_sim;
   end

   initial
   begin
      // a real falling edge, so the link-side synchroniser clears with no strobe running
      resetn_i <= 0;
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1;
      repeat (3) @(posedge ref_clk_i);
      for (int a = 0; a < 24; a += 4)
         apb(0, 12'(a), 0, 4'hF, {a > 16, 32'h0});
      repeat (16)
      begin
         @(posedge ref_clk_i);
         t = 1'($random(seed));
         tristate_ctrl_in_i <= t;
         tq_c.push_back(cyc + 2);
         tq_v.push_back(t);
      end
      // write without lane strobes must leave the mode alone
      apb(1, 12'h000, 32'h1, 4'h0, 0);
      apb(0, 12'h000, 0, 4'hF, 33'h0);
      apb(1, 12'h000, 32'h1, 4'h1, 0);
      apb(0, 12'h000, 0, 4'hF, 33'h1);
      // held pairs make the check independent of the phase
      for (int p = 0; p < 3; p++)
         for (int j = 0; j < 6; j++)
         begin
            @(posedge ref_clk_i);
            tristate_ctrl_in_i <= 1'($random(seed));
            tristate_pair_in_i <= (p == 2) ? 2'($random(seed)) : {2{p == 0}};
            if (p < 2 && j >= 2)
            begin
               tq_c.push_back(cyc + 2);
               tq_v.push_back(p == 0);
            end
         end
      apb(1, 12'h000, 32'h0, 4'hF, 0);
      for (int i = 0; i < 3; i++)
      begin
         v = 9'h010 + {1'b0, 8'($random(seed))};
         delay_code_in_i <= v;
         mg(i, 3'h0);
         mg(i, 3'h4);
         mg(i, 3'h6);
         mg(i, 3'h4);
         mg(i, 3'h6);
         mg(i, 3'h4);
         repeat (3) mg(i, 3'h7);
         mg(i, 3'h4);
         apb(0, 12'h008 + 12'(4 * i), 0, 4'hF, {24'h0, v + 9'h1});
         delay_code_in_i <= 9'h1FF;
         mg(i, 3'h0);
         mg(i, 3'h4);
         mg(i, 3'h6);
         mg(i, 3'h4);
         apb(0, 12'h008 + 12'(4 * i), 0, 4'hF, {24'h0, 9'h1FF});
      end
      apb(0, 12'h004, 0, 4'hF, 33'h0_000E_0000);
      @(negedge ref_clk_i);
      `CHK({read_count_out_o, write_count_out_o}, 2'b11)
      for (int b = 0; b < 2; b++)
      begin
         @(posedge ref_clk_i);
         read_ind_i <= 2'(b + 1);
         read_pulse_select_i <= 3'($random(seed));
         repeat (12) @(posedge ref_clk_i);
         n_edges <= 4'(6 - b); // strobe outpaces the edge clock, so bursts stay short
         go <= 1;
         @(posedge ref_clk_i);
         go <= 0;
         repeat (4) @(posedge ref_clk_i);
         read_ind_i <= 0;
         w = 0;
         do @(negedge ref_clk_i); while (burst_detect_flag_o !== 1'b1 && ++w < 60);
         `CHK(w < 60, 1'b1)
      end
      `CHK(n_valid, 2)
      // first burst loses two strobes to the link reset release and two to the sync
      apb(0, 12'h004, 0, 4'hF, 33'h0_000F_0077);
      apb(1, 12'h004, 32'h0001_0000, 4'h4, 0);
      apb(0, 12'h004, 0, 4'hF, 33'h0_000E_0077);
      @(posedge ref_clk_i);
      resetn_i <= 0;
      tristate_ctrl_in_i <= 1;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      `CHK({tristate_ctrl_out_o, delay_code_out_o}, 10'h0)
      `CHK({fifo_read_pointer_o[0], fifo_write_pointer_o[0]}, 6'h0)
      @(posedge ref_clk_i);
      resetn_i <= 1;
      repeat (3) @(posedge ref_clk_i);
      apb(0, 12'h000, 0, 4'hF, 33'h0);
      end_sim;
   end
endmodule // tb_ddr_strobe_and_tristate_io

bind dsd_strobe_top dsd_strobe_monitor #(.GROUP_PINS(GROUP_PINS)) u_mon (.*);
